// >>> hw/bcl_ctrl.sv
// Bus cycle, lock and pseudo-lock control
`timescale 1ns/1ns
module bcl_ctrl (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire bcl_pkg::bcl_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  output logic cycle_done,
  input wire logic ready_n,
  input wire logic size8_req_n,
  input wire logic size16_req_n,
  input wire logic cacheable_n,
  input wire logic hold_req,
  output logic hold_ack,
  output logic [29:0] addr,
  output logic [3:0] byte_enable_n,
  output bcl_pkg::bcl_def_t cycle_def,
  output logic addr_strobe_n,
  output logic addr_strobe_oe,
  output logic lock_n,
  output logic lock_oe,
  output logic pseudo_lock_n,
  output logic pseudo_lock_oe
);
  import bcl_pkg::*;

  typedef enum {ST_IDLE, ST_T1, ST_T2} bcl_state_t;

  bcl_state_t state, next_state;
  logic [2:0] rdy_sync, next_rdy_sync;
  logic [2:0] beats, next_beats;
  logic [2:0] total, next_total;
  logic [29:0] next_addr;
  logic [3:0] next_byte_enable_n;
  bcl_def_t next_cycle_def;
  logic next_addr_strobe_n, next_lock_n, next_pseudo_lock_n;
  logic next_hold_ack, next_req_ready, next_cycle_done;
  logic next_addr_strobe_oe, next_lock_oe, next_pseudo_lock_oe;
  logic lock_keep, next_lock_keep;
  logic multi, next_multi;
  logic rdy_seen;

  // Three-stage pin synchroniser for ready
  always_comb begin
    next_rdy_sync = {rdy_sync[1:0], ready_n};
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdy_sync <= 3'h7;
    end else begin
      rdy_sync <= next_rdy_sync;
    end
  end

  // Ready change counts once second and third stages agree
  assign rdy_seen = ~rdy_sync[1] & ~rdy_sync[2];

  always_comb begin
    next_state = state;
    next_beats = beats;
    next_total = total;
    next_addr = addr;
    next_byte_enable_n = byte_enable_n;
    next_cycle_def = cycle_def;
    next_addr_strobe_n = 1'b1;
    next_lock_n = lock_n;
    next_pseudo_lock_n = pseudo_lock_n;
    next_hold_ack = hold_ack;
    next_req_ready = 1'b0;
    next_cycle_done = 1'b0;
    next_lock_keep = lock_keep;
    next_multi = multi;
    case (state)
      ST_IDLE: begin
        // Ready is not looked at here
        next_hold_ack = hold_req & lock_n;
        if (req_valid && !hold_req && !hold_ack) begin
          next_state = ST_T1;
          next_req_ready = 1'b1;
          next_addr = req.addr;
          next_byte_enable_n = req.byte_enable_n;
          next_addr_strobe_n = 1'b0;
          next_beats = 3'h1;
          next_lock_keep = req.locked & ~req.last_locked;
          if (req.locked) begin
            next_lock_n = 1'b0;
          end
          case (req.op)
            BCL_OP_INTA: next_cycle_def = 3'b000;
            BCL_OP_SPECIAL: next_cycle_def = 3'b001;
            BCL_OP_IO_RD: next_cycle_def = 3'b010;
            BCL_OP_IO_WR: next_cycle_def = 3'b011;
            BCL_OP_CODE_RD: next_cycle_def = 3'b100;
            BCL_OP_MEM_RD: next_cycle_def = 3'b110;
            BCL_OP_MEM_WR: next_cycle_def = 3'b111;
            default: next_cycle_def = 3'b110;
          endcase
          if (req.op == BCL_OP_SPECIAL) begin
            case (req.special)
              BCL_SP_SHUTDOWN: begin
                next_byte_enable_n = BE_SHUTDOWN;
                next_addr = {req.addr[29:3], A42_SHUTDOWN};
              end
              BCL_SP_HALT: begin
                next_byte_enable_n = BE_HALT;
                next_addr = {req.addr[29:3], A42_HALT};
              end
              BCL_SP_STOPGNT: begin
                next_byte_enable_n = BE_STOPGNT;
                next_addr = {req.addr[29:3], A42_STOPGNT};
              end
              default: next_byte_enable_n = BE_IDLE_N;
            endcase
          end
          // Locked reads are never line fills
          next_multi = (req.line_fill & ~req.locked) | req.desc_read;
          next_total = req.desc_read ? DESC_BEATS : LINE_BEATS;
          next_pseudo_lock_n = ~next_multi;
        end
      end
      ST_T1: begin
        // First clock: ready ignored
        next_state = ST_T2;
      end
      ST_T2: begin
        if (rdy_seen) begin
          if (multi && beats < total &&
              (!cacheable_n || !size8_req_n || !size16_req_n)) begin
            // Narrow bus or still cacheable: another address phase
            next_state = ST_T1;
            next_beats = 3'(beats + 3'h1);
            next_addr = 30'(addr + 30'h1);
            next_addr_strobe_n = 1'b0;
            // Released as final address goes out
            next_pseudo_lock_n = (3'(beats + 3'h1) == total);
          end else begin
            next_state = ST_IDLE;
            next_cycle_done = 1'b1;
            next_multi = 1'b0;
            next_pseudo_lock_n = 1'b1;
            if (!lock_keep) begin
              next_lock_n = 1'b1;
            end
          end
          // Wide bus and not cacheable: no further cycle
          if (multi && cacheable_n && size8_req_n && size16_req_n) begin
            next_pseudo_lock_n = 1'b1;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      beats <= 3'h0;
      total <= 3'h0;
      addr <= 30'h0;
      byte_enable_n <= BE_IDLE_N;
      cycle_def <= 3'h0;
      addr_strobe_n <= 1'b1;
      lock_n <= 1'b1;
      pseudo_lock_n <= 1'b1;
      hold_ack <= 1'b0;
      req_ready <= 1'b0;
      cycle_done <= 1'b0;
      lock_keep <= 1'b0;
      multi <= 1'b0;
    end else begin
      state <= next_state;
      beats <= next_beats;
      total <= next_total;
      addr <= next_addr;
      byte_enable_n <= next_byte_enable_n;
      cycle_def <= next_cycle_def;
      addr_strobe_n <= next_addr_strobe_n;
      lock_n <= next_lock_n;
      pseudo_lock_n <= next_pseudo_lock_n;
      hold_ack <= next_hold_ack;
      req_ready <= next_req_ready;
      cycle_done <= next_cycle_done;
      lock_keep <= next_lock_keep;
      multi <= next_multi;
    end
  end

  // Strobe, lock and pseudo-lock outputs float while hold is granted
  always_comb begin
    next_addr_strobe_oe = ~next_hold_ack;
    next_lock_oe = ~next_hold_ack;
    next_pseudo_lock_oe = ~next_hold_ack;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      addr_strobe_oe <= 1'b1;
      lock_oe <= 1'b1;
      pseudo_lock_oe <= 1'b1;
    end else begin
      addr_strobe_oe <= next_addr_strobe_oe;
      lock_oe <= next_lock_oe;
      pseudo_lock_oe <= next_pseudo_lock_oe;
    end
  end
endmodule // bcl_ctrl

// >>> hw/bcl_pkg.sv
// Package for the bus cycle and lock control block
package bcl_pkg;
  localparam logic [3:0] BE_SHUTDOWN = 4'he;
  localparam logic [3:0] BE_HALT = 4'hb;
  localparam logic [3:0] BE_STOPGNT = 4'hb;
  localparam logic [2:0] A42_SHUTDOWN = 3'h0;
  localparam logic [2:0] A42_HALT = 3'h0;
  localparam logic [2:0] A42_STOPGNT = 3'h4;
  localparam logic [3:0] BE_IDLE_N = 4'hf;
  localparam logic [2:0] LINE_BEATS = 3'h4;
  localparam logic [2:0] DESC_BEATS = 3'h2;

  typedef enum logic [2:0] {
    BCL_OP_INTA, BCL_OP_SPECIAL, BCL_OP_IO_RD, BCL_OP_IO_WR,
    BCL_OP_CODE_RD, BCL_OP_MEM_RD, BCL_OP_MEM_WR
  } bcl_op_t;

  typedef enum logic [1:0] {
    BCL_SP_SHUTDOWN, BCL_SP_HALT, BCL_SP_STOPGNT
  } bcl_special_t;

  typedef struct packed {
    bcl_op_t op;
    bcl_special_t special;
    logic [29:0] addr;
    logic [3:0] byte_enable_n;
    logic locked;
    logic last_locked;
    logic line_fill;
    logic desc_read;
  } bcl_req_t;

  typedef struct packed {
    logic mem_io;
    logic data_code;
    logic write_read;
  } bcl_def_t;
endpackage

// >>> tb/bcl_ctrl_sva.sv
// Checker for the bus cycle and lock control ports
`timescale 1ns/1ns
module bcl_ctrl_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire bcl_pkg::bcl_req_t req,
  input wire logic req_ready,
  input wire logic cycle_done,
  input wire logic hold_ack,
  input wire logic [29:0] addr,
  input wire logic [3:0] byte_enable_n,
  input wire bcl_pkg::bcl_def_t cycle_def,
  input wire logic addr_strobe_n,
  input wire logic addr_strobe_oe,
  input wire logic lock_n,
  input wire logic lock_oe,
  input wire logic pseudo_lock_n,
  input wire logic pseudo_lock_oe
);
  import bcl_pkg::*;
  logic [2:0] def_of [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_strobe_taken:
    assert property (req_ready |-> !addr_strobe_n)
    else $error("strobe missing at request");
  chk_special_code:
    assert property (req_ready && req.op == BCL_OP_SPECIAL |->
      {byte_enable_n, addr[2:0]} == (req.special == BCL_SP_SHUTDOWN ?
      {BE_SHUTDOWN, A42_SHUTDOWN} : req.special == BCL_SP_HALT ?
      {BE_HALT, A42_HALT} : {BE_STOPGNT, A42_STOPGNT}))
    else $error("special cycle code wrong");
  chk_def_enc:
    assert property (req_ready |-> cycle_def == def_of[req.op])
    else $error("cycle definition wrong");
  chk_hold_float:
    assert property (hold_ack |-> addr_strobe_n && !addr_strobe_oe &&
      !lock_oe && !pseudo_lock_oe) else $error("driving during hold");
  chk_lock_release:
    assert property ($rose(lock_n) |-> cycle_done)
    else $error("lock released early");
  chk_pseudo_lock_n_release:
    assert property ($rose(pseudo_lock_n) |-> cycle_done || !addr_strobe_n)
    else $error("pseudo lock released early");
  chk_pseudo_lock_n_desc:
    assert property (req_ready && req.desc_read |-> ##[0:1] !pseudo_lock_n)
    else $error("pseudo lock missing");
  chk_locked_fill:
    assert property (req_ready && req.locked && req.line_fill |->
      pseudo_lock_n [*4]) else $error("locked read became fill");
endmodule // bcl_ctrl_sva
bind bcl_ctrl bcl_ctrl_sva u_bcl_ctrl_sva (.*);

// >>> tb/bcl_far_model.sv
// Far-side model returning a two-clock ready every eighth clock
`timescale 1ns/1ns
module bcl_far_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cycle_done,
  input wire logic addr_strobe_n,
  input wire logic pseudo_lock_n,
  input wire logic stray,
  output logic ready_n = 1'b1,
  output logic pseudo_lock_n_seen = 1'b0
);
  logic busy = 1'b0;
  logic [3:0] cnt = 4'h0;
  always @(negedge core_clk) begin
    if (!rst_n || cycle_done) busy <= 1'b0;
    else if (!addr_strobe_n) busy <= 1'b1;
    cnt <= busy ? cnt + 4'h1 : 4'h0;
    ready_n <= !(stray || (busy && (cnt[2:0] == 3'h3 ||
      cnt[2:0] == 3'h4)));
    // Pseudo-lock read only while ready stands
    if (!ready_n) pseudo_lock_n_seen <= !pseudo_lock_n;
  end
endmodule // bcl_far_model

// >>> tb/bcl_ctrl_bench.sv
// Self-checking bench for bus cycle and lock control
`timescale 1ns/1ns
module bcl_ctrl_bench;
  import bcl_pkg::*;
  logic core_clk = 0, rst_n = 0, req_valid = 0, hold_req = 0, stray = 0;
  logic size8_req_n = 1, size16_req_n = 1, cacheable_n = 1, pl_low;
  logic ready_n, req_ready, cycle_done, hold_ack, addr_strobe_n, lock_n;
  logic addr_strobe_oe, lock_oe, pseudo_lock_n, pseudo_lock_oe, pseudo_lock_n_seen;
  logic [29:0] addr;
  logic [3:0] byte_enable_n;
  logic [10:0] cap;
  bcl_def_t cycle_def;
  bcl_req_t req = '0;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  bcl_op_t t_op [9] = '{BCL_OP_INTA, BCL_OP_SPECIAL, BCL_OP_IO_RD,
    BCL_OP_IO_WR, BCL_OP_CODE_RD, BCL_OP_MEM_RD, BCL_OP_MEM_WR,
    BCL_OP_SPECIAL, BCL_OP_SPECIAL};
  logic [1:0] t_sp [9] = '{2'h0,2'h0,2'h0,2'h0,2'h0,2'h0,2'h0,2'h1,2'h2};
  // Strobe, definition, byte enables, A4..A2
  logic [10:0] t_out [9] = '{11'h003, 11'h0f0, 11'h103, 11'h183, 11'h203,
    11'h303, 11'h383, 11'h0d8, 11'h0dc};
  bcl_ctrl u_bcl_ctrl (.*);
  bcl_far_model u_bcl_far_model (.*);
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
  task summarize;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function bcl_req_t rq(bcl_op_t o, logic [3:0] f);
    rq = '0;
    rq.op = o;
    rq.addr = 30'h3;
    {rq.locked, rq.last_locked, rq.line_fill, rq.desc_read} = f;
  endfunction
  task go(input bcl_req_t r);
    repeat (6) @(negedge core_clk);
    req = r;
    req_valid = 1;
    for (int k = 0; k < 20 && req_ready !== 1'b1; k++) @(negedge core_clk);
    cap = {addr_strobe_n, cycle_def, byte_enable_n, addr[2:0]};
    pl_low = !pseudo_lock_n;
    req_valid = 0;
    for (int k = 0; k < 99 && cycle_done !== 1'b1; k++) begin
      @(negedge core_clk);
      pl_low |= !pseudo_lock_n;
    end
    chk(cycle_done, 1);
  endtask
  initial begin
    bcl_req_t r;
    repeat (3) @(negedge core_clk);
    chk({addr_strobe_n, lock_n, pseudo_lock_n, addr_strobe_oe, lock_oe,
      pseudo_lock_oe, byte_enable_n, addr}, {10'h3ff, 30'h0});
    @(negedge core_clk) rst_n = 1;
    for (int i = 0; i < 9; i++) begin
      r = rq(t_op[i], 4'h0);
      r.special = bcl_special_t'(t_sp[i]);
      go(r);
      chk(cap, t_out[i]);
    end
    go(rq(BCL_OP_MEM_RD, 4'h8));
    chk(lock_n, 0);
    go(rq(BCL_OP_MEM_WR, 4'hc));
    chk(lock_n, 1);
    go(rq(BCL_OP_MEM_RD, 4'h1));
    chk({pl_low, pseudo_lock_n, pseudo_lock_n_seen}, 3'h7);
    cacheable_n = 0;
    go(rq(BCL_OP_MEM_RD, 4'h2));
    chk({pl_low, pseudo_lock_n, pseudo_lock_n_seen}, 3'h6);
    go(rq(BCL_OP_MEM_RD, 4'he));
    chk({pl_low, lock_n}, 2'h1);
    cacheable_n = 1;
    size8_req_n = 0;
    go(rq(BCL_OP_MEM_RD, 4'h2));
    chk({pl_low, pseudo_lock_n}, 2'h3);
    @(negedge core_clk) stray = 1;
    repeat (2) @(negedge core_clk);
    stray = 0;
    repeat (8) @(negedge core_clk) chk(cycle_done, 0);
    hold_req = 1;
    for (int k = 0; k < 20 && hold_ack !== 1'b1; k++) @(negedge core_clk);
    chk({hold_ack, addr_strobe_oe, lock_oe, pseudo_lock_oe}, 4'h8);
    summarize();
  end
endmodule // bcl_ctrl_bench
